// File: adcsc_pkg.sv
/*
 * Package for the converter sequence control block: register offsets,
 * field positions, reset values, timing and mode enumerations.
 * Assumes a byte-wide register port with printed byte offsets.
 */
package adcsc_pkg;

    // Register offsets (byte addresses)
    localparam logic [15:0] ADCSC_RES_LOW_BASE  = 16'h12A0;
    localparam logic [15:0] ADCSC_RES_HIGH_CH4  = 16'h12A9;
    localparam logic [15:0] ADCSC_MODE0_ADDR    = 16'h12B0;
    localparam logic [15:0] ADCSC_MODE1_ADDR    = 16'h12B1;
    localparam logic [15:0] ADCSC_MODE2_ADDR    = 16'h12B2;

    // Mode control 0 fields
    localparam int ADCSC_M0_START  = 0;
    localparam int ADCSC_M0_SCAN   = 1;
    localparam int ADCSC_M0_REPEAT = 2;
    localparam int ADCSC_M0_ITM    = 3;
    localparam int ADCSC_M0_BUSY   = 6;
    localparam int ADCSC_M0_END    = 7;
    // Mode control 1 fields
    localparam int ADCSC_M1_CH_LSB = 0;
    localparam int ADCSC_M1_I2RUN  = 5;
    localparam int ADCSC_M1_REFON  = 7;
    // Mode control 2 fields
    localparam int ADCSC_M2_TRGE   = 0;

    localparam logic [2:0] ADCSC_CH_RESET = 3'h0;
    localparam logic [2:0] ADCSC_CH_MAX   = 3'h4;
    localparam logic [4:0] ADCSC_LOW_ONES = 5'h1F;
    localparam int         ADCSC_NUM_CH   = 5;

    // One channel takes 132 system states
    localparam int          ADCSC_CONV_STATES = 132;
    localparam logic [7:0]  ADCSC_CONV_CYCLES = 8'(ADCSC_CONV_STATES);
    localparam logic [1:0]  ADCSC_EVERY_4TH   = 2'h3;

    typedef enum logic [1:0] {
        ADCSC_FIX_SINGLE,
        ADCSC_SCAN_SINGLE,
        ADCSC_FIX_REPEAT,
        ADCSC_SCAN_REPEAT
    } adcsc_mode_t;

    typedef enum logic [1:0] {
        ADCSC_IDLE,
        ADCSC_CONVERT,
        ADCSC_HALTED
    } adcsc_state_t;

endpackage : adcsc_pkg

// File: adcsc_sar.sv
/*
 * Successive-approximation stepper: runs one conversion of fixed length
 * and returns the ten-bit code. Assumes the comparator output is a
 * synchronised input valid every cycle of the search.
 */
`timescale 1ns/1ps
module adcsc_sar
    import adcsc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Control
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic       cmp_i,
    // Result
    output logic [9:0]      trial_o,
    output logic            done_o,
    output logic [9:0]      code_o
);
    logic [7:0] cnt_reg;
    logic [9:0] bit_reg;
    logic       run_reg;

    // Ten bit decisions spread over the fixed window; the rest is sampling
    always_ff @(posedge clk_i) begin
        if (srst_i || abort_i) begin
            cnt_reg <= 8'h00;
            run_reg <= 1'b0;
            bit_reg <= 10'h200;
            trial_o <= 10'h000;
            done_o  <= 1'b0;
            code_o  <= 10'h000;
        end else begin
            done_o <= 1'b0;
            if (start_i && !run_reg) begin
                run_reg <= 1'b1;
                cnt_reg <= 8'h01;
                bit_reg <= 10'h200;
                trial_o <= 10'h200;
            end else if (run_reg) begin
                cnt_reg <= cnt_reg + 8'h01;
                // Every eighth cycle gives ten decisions well inside the window
                if (cnt_reg[2:0] == 3'h7 && bit_reg != 10'h000) begin
                    if (!cmp_i) begin
                        trial_o <= (trial_o & ~bit_reg) | (bit_reg >> 1);
                    end else begin
                        trial_o <= trial_o | (bit_reg >> 1);
                    end
                    bit_reg <= bit_reg >> 1;
                end
                if (cnt_reg == ADCSC_CONV_CYCLES - 8'h01) begin
                    run_reg <= 1'b0;
                    done_o  <= 1'b1;
                    code_o  <= trial_o;
                end
            end
        end
    end

endmodule : adcsc_sar

// File: adcsc_top.sv
/*
 * Sequence and result control of a ten-bit converter: channel select,
 * four conversion modes, start sources, busy/end flags, result storage.
 * Assumes a byte register port with read data one cycle after the strobe
 * and an analog front end that only needs the channel, trial code and ladder switch.
 */
// Overview of operation
// - High byte upper bits; low bits 7:6, ones
// - Bit0 stored flag, cleared by pair read
// - Fixed mode code picks inputs 0..4; a start in the write that clears scan first converts input 0
// - Scan code n converts inputs 0..n; a start in the write that sets scan first converts only input n
// - Reset clears scan, channel select zero
// - Start by bit or enabled falling trigger
// - Busy set at start, held meanwhile
// - Trigger edges ignored while converting
// - Completion sets end flag, pulses irq
// - Repeat and scan bits select mode
// - Fixed single: once, end, unbusy, irq
// - Scan single: whole scan then end
// - Fixed repeat: irq each or fourth
// - Scan repeat: irq after each scan
// - Clearing repeat finishes current, clears busy
// - Halt modes abort conversion immediately
// - After halt, repeat restarts, single stays
// - One channel takes 132 states
// - Fixed repeat fourth: cyclic pairs 0..3
// - Result read clears end flag
`timescale 1ns/1ps
module adcsc_top
    import adcsc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Register port
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Trigger pin and power modes
    input  wire logic        ext_trigger_pin_n_i,
    input  wire logic        deep_idle_mode_i,
    input  wire logic        stop_mode_i,
    input  wire logic        light_idle_mode_i,
    // Analog front end
    input  wire logic        cmp_i,
    output logic      [2:0]  analog_channel_o,
    output logic      [9:0]  dac_trial_o,
    output logic             ref_ladder_switch_o,
    output logic             conv_done_irq_o
);
    // Control bits
    logic        scan_reg;
    logic        repeat_reg;
    logic        itm_reg;
    logic [2:0]  input_channel_select_reg;
    logic        light_idle_run_enable_reg;
    logic        ref_ladder_switch_reg;
    logic        ext_trigger_enable_reg;
    logic        conv_busy_flag_reg;
    logic        conv_end_flag_reg;
    // Sequencer
    adcsc_state_t state_reg;
    logic [2:0]  chan_reg;
    logic [1:0]  quad_reg;
    logic        was_repeat_reg;
    // Results
    logic [9:0]  result_mem [ADCSC_NUM_CH];
    logic [ADCSC_NUM_CH-1:0] result_stored_flag_reg;
    // Pin synchroniser and edge detector
    logic        trg_s1_reg;
    logic        trg_s2_reg;
    logic        trg_s3_reg;

    logic        halt_req;
    logic        trg_fall;
    logic        sw_start;
    logic        start_req;
    logic        sar_start_reg;
    logic        sar_done;
    logic [9:0]  sar_code;
    logic [9:0]  sar_trial;
    adcsc_mode_t mode;
    logic        last_in_scan;
    logic [2:0]  store_pair;
    logic        res_rd;
    logic [2:0]  rd_pair;

    function automatic logic [2:0] pair_of(input logic [15:0] a);
        logic [15:0] off;
        off = a - ADCSC_RES_LOW_BASE;
        return off[3:1];
    endfunction : pair_of

    function automatic logic is_result(input logic [15:0] a);
        return (a >= ADCSC_RES_LOW_BASE) && (a <= ADCSC_RES_HIGH_CH4);
    endfunction : is_result

    assign mode      = adcsc_mode_t'({repeat_reg, scan_reg});
    assign halt_req  = deep_idle_mode_i || stop_mode_i
                       || (light_idle_mode_i && !light_idle_run_enable_reg);
    assign trg_fall  = trg_s3_reg && !trg_s2_reg;
    assign sw_start  = wr_i && (addr_i == ADCSC_MODE0_ADDR) && wdata_i[ADCSC_M0_START];
    assign start_req = (sw_start || (ext_trigger_enable_reg && trg_fall))
                       && (state_reg == ADCSC_IDLE) && !halt_req;
    assign last_in_scan = !scan_reg || (chan_reg >= input_channel_select_reg);
    assign res_rd    = rd_i && is_result(addr_i);
    assign rd_pair   = pair_of(addr_i);

    // Result pair chosen per mode
    always_comb begin
        if (mode == ADCSC_FIX_REPEAT) begin
            store_pair = itm_reg ? {1'b0, quad_reg} : 3'h0;
        end else begin
            store_pair = chan_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            trg_s1_reg <= 1'b1;
            trg_s2_reg <= 1'b1;
            trg_s3_reg <= 1'b1;
        end else begin
            trg_s1_reg <= ext_trigger_pin_n_i;
            trg_s2_reg <= trg_s1_reg;
            trg_s3_reg <= trg_s2_reg;
        end
    end

    // Software control bits
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            scan_reg                  <= 1'b0;
            input_channel_select_reg  <= ADCSC_CH_RESET;
            repeat_reg                <= 1'b0;
            itm_reg                   <= 1'b0;
            light_idle_run_enable_reg <= 1'b0;
            ref_ladder_switch_reg     <= 1'b0;
            ext_trigger_enable_reg    <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == ADCSC_MODE0_ADDR) begin
                scan_reg   <= wdata_i[ADCSC_M0_SCAN];
                repeat_reg <= wdata_i[ADCSC_M0_REPEAT];
                itm_reg    <= wdata_i[ADCSC_M0_ITM];
            end
            if (addr_i == ADCSC_MODE1_ADDR) begin
                // Codes above four fold to input four: only five inputs exist
                if (wdata_i[ADCSC_M1_CH_LSB +: 3] > ADCSC_CH_MAX) begin
                    input_channel_select_reg <= ADCSC_CH_MAX;
                end else begin
                    input_channel_select_reg <= wdata_i[ADCSC_M1_CH_LSB +: 3];
                end
                light_idle_run_enable_reg <= wdata_i[ADCSC_M1_I2RUN];
                // Settling after switch-on is left to software timing
                ref_ladder_switch_reg     <= wdata_i[ADCSC_M1_REFON];
            end
            if (addr_i == ADCSC_MODE2_ADDR) begin
                ext_trigger_enable_reg <= wdata_i[ADCSC_M2_TRGE];
            end
        end
    end

    // Sequencer: channel stepping, repeat, halt handling
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg          <= ADCSC_IDLE;
            chan_reg           <= 3'h0;
            quad_reg           <= 2'h0;
            was_repeat_reg     <= 1'b0;
            sar_start_reg      <= 1'b0;
            conv_busy_flag_reg <= 1'b0;
        end else begin
            sar_start_reg <= 1'b0;
            case (state_reg)
                ADCSC_IDLE: begin
                    if (start_req) begin
                        state_reg          <= ADCSC_CONVERT;
                        chan_reg           <= scan_reg ? 3'h0 : input_channel_select_reg;
                        quad_reg           <= 2'h0;
                        sar_start_reg      <= 1'b1;
                        conv_busy_flag_reg <= 1'b1;
                    end
                end
                ADCSC_CONVERT: begin
                    if (halt_req) begin
                        state_reg      <= ADCSC_HALTED;
                        was_repeat_reg <= repeat_reg;
                    end else if (sar_done) begin
                        quad_reg <= quad_reg + 2'h1;
                        if (!last_in_scan) begin
                            chan_reg      <= chan_reg + 3'h1;
                            sar_start_reg <= 1'b1;
                        end else if (repeat_reg) begin
                            chan_reg      <= scan_reg ? 3'h0 : input_channel_select_reg;
                            sar_start_reg <= 1'b1;
                        end else begin
                            state_reg          <= ADCSC_IDLE;
                            conv_busy_flag_reg <= 1'b0;
                        end
                    end
                end
                ADCSC_HALTED: begin
                    if (!halt_req) begin
                        if (was_repeat_reg && repeat_reg) begin
                            state_reg     <= ADCSC_CONVERT;
                            chan_reg      <= scan_reg ? 3'h0 : input_channel_select_reg;
                            quad_reg      <= 2'h0;
                            sar_start_reg <= 1'b1;
                        end else begin
                            state_reg          <= ADCSC_IDLE;
                            conv_busy_flag_reg <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg <= ADCSC_IDLE;
                end
            endcase
        end
    end

    adcsc_sar u_sar (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .start_i (sar_start_reg),
        .abort_i (halt_req),
        .cmp_i   (cmp_i),
        .trial_o (sar_trial),
        .done_o  (sar_done),
        .code_o  (sar_code)
    );

    // End flag and interrupt; a completion beats a same-cycle read clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_end_flag_reg <= 1'b0;
            conv_done_irq_o   <= 1'b0;
        end else begin
            conv_done_irq_o <= 1'b0;
            if (state_reg == ADCSC_CONVERT && sar_done && !halt_req && last_in_scan
                && !(mode == ADCSC_FIX_REPEAT && itm_reg && quad_reg != ADCSC_EVERY_4TH)) begin
                conv_end_flag_reg <= 1'b1;
                conv_done_irq_o   <= 1'b1;
            end else if (res_rd) begin
                conv_end_flag_reg <= 1'b0;
            end
        end
    end

    // Result storage with per-pair stored flags; store beats read clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            result_stored_flag_reg <= '0;
            for (int i = 0; i < ADCSC_NUM_CH; i++) begin
                result_mem[i] <= 10'h000;
            end
        end else begin
            for (int i = 0; i < ADCSC_NUM_CH; i++) begin
                if (state_reg == ADCSC_CONVERT && sar_done && !halt_req
                    && store_pair == 3'(i)) begin
                    result_mem[i]             <= sar_code;
                    result_stored_flag_reg[i] <= 1'b1;
                end else if (res_rd && rd_pair == 3'(i)) begin
                    result_stored_flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Read data, valid in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (is_result(addr_i)) begin
                if (addr_i[0]) begin
                    rdata_o <= result_mem[rd_pair][9:2];
                end else begin
                    rdata_o <= {result_mem[rd_pair][1:0], ADCSC_LOW_ONES,
                                result_stored_flag_reg[rd_pair]};
                end
            end else if (addr_i == ADCSC_MODE0_ADDR) begin
                rdata_o <= {conv_end_flag_reg, conv_busy_flag_reg, 2'h0,
                            itm_reg, repeat_reg, scan_reg, 1'b0};
            end else if (addr_i == ADCSC_MODE1_ADDR) begin
                rdata_o <= {ref_ladder_switch_reg, 1'b0, light_idle_run_enable_reg,
                            2'h0, input_channel_select_reg};
            end else if (addr_i == ADCSC_MODE2_ADDR) begin
                rdata_o <= {7'h00, ext_trigger_enable_reg};
            end else begin
                rdata_o <= 8'h00;
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Front-end drive
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            analog_channel_o    <= 3'h0;
            dac_trial_o         <= 10'h000;
            ref_ladder_switch_o <= 1'b0;
        end else begin
            analog_channel_o    <= chan_reg;
            dac_trial_o         <= sar_trial;
            ref_ladder_switch_o <= ref_ladder_switch_reg;
        end
    end

    a_busy_start: assert property (@(posedge clk_i) disable iff (srst_i)
        start_req |=> conv_busy_flag_reg)
        else $error("busy not set after start");
    a_trg_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ADCSC_CONVERT && trg_fall && !sw_start)
        |=> !sar_start_reg || $past(sar_done))
        else $error("trigger started a busy converter");
    a_halt_abort: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ADCSC_CONVERT && halt_req) |=> state_reg == ADCSC_HALTED)
        else $error("halt did not abort");
    a_read_clears: assert property (@(posedge clk_i) disable iff (srst_i)
        (res_rd && !(state_reg == ADCSC_CONVERT && sar_done)) |=> !conv_end_flag_reg)
        else $error("end flag survived result read");
    a_reset_chan: assert property (@(posedge clk_i)
        srst_i |=> (input_channel_select_reg == 3'h0 && !scan_reg))
        else $error("channel select not reset");
    a_single_end: assert property (@(posedge clk_i) disable iff (srst_i)
        (conv_done_irq_o && !repeat_reg && !$past(repeat_reg)) |-> !conv_busy_flag_reg)
        else $error("single mode left busy set");
    a_conv_time: assert property (@(posedge clk_i) disable iff (srst_i || halt_req)
        sar_start_reg |-> ##132 sar_done)
        else $error("conversion length wrong");
    a_repeat_busy: assert property (@(posedge clk_i) disable iff (srst_i)
        (conv_done_irq_o && repeat_reg && $past(repeat_reg) && !halt_req) |-> conv_busy_flag_reg)
        else $error("repeat mode dropped busy");
    c_fix_single: cover property (@(posedge clk_i) mode == ADCSC_FIX_SINGLE && conv_done_irq_o);
    c_scan_rep: cover property (@(posedge clk_i) mode == ADCSC_SCAN_REPEAT && conv_done_irq_o);
    c_fourth: cover property (@(posedge clk_i) itm_reg && mode == ADCSC_FIX_REPEAT && conv_done_irq_o);
    c_halt: cover property (@(posedge clk_i) state_reg == ADCSC_HALTED);

endmodule : adcsc_top

// File: adcsc_afe_model.sv
/*
 * Analog front end model: one fixed level per input and a comparator
 * against the trial code. Assumes channel and trial come from registers.
 */
`timescale 1ns/1ps
module adcsc_afe_model (
    // Converter side
    input  wire logic       clk_i,
    input  wire logic [2:0] analog_channel_i,
    input  wire logic [9:0] dac_trial_i,
    input  wire logic       ref_ladder_switch_i,
    // Comparator
    output logic            cmp_o
);
    logic [9:0] level;
    logic       junk_reg = 1'b0;

    // Level sits half a step above a code, so either compare sense gives it
    assign level = 10'h041 + 10'(analog_channel_i) * 10'h0B7;

    // With the ladder open the comparator output means nothing
    always @(posedge clk_i) begin
        junk_reg <= ~junk_reg;
    end

    assign cmp_o = ref_ladder_switch_i ? ({level, 1'b1} > {dac_trial_i, 1'b0}) : junk_reg;
endmodule : adcsc_afe_model

// File: tb.sv
/*
 * Self-checking bench for the converter sequence control block.
 * Assumes the package register map and the front end model beside it.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, (g), (e)); end end
module tb
    import adcsc_pkg::*;
();
    localparam logic [15:0] M0 = ADCSC_MODE0_ADDR;
    localparam logic [15:0] M1 = ADCSC_MODE1_ADDR;
    localparam logic [15:0] M2 = ADCSC_MODE2_ADDR;
    logic        clk   = 1'b0;
    logic        srst  = 1'b1;
    logic [15:0] addr  = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        trg_n = 1'b1;
    logic        deep  = 1'b0;
    logic        stopm = 1'b0;
    logic        light = 1'b0;
    logic        cmp;
    logic [7:0]  rdata;
    logic [2:0]  ach;
    logic [9:0]  trial;
    logic        ladder;
    logic        irq;
    logic [7:0]  d;
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    int          irqs       = 0;
    int          n;
    int          base;

    adcsc_top adcsc_top_i (
        .clk_i               (clk),
        .srst_i              (srst),
        .addr_i              (addr),
        .wdata_i             (wdata),
        .wr_i                (wr),
        .rd_i                (rd),
        .rdata_o             (rdata),
        .ext_trigger_pin_n_i (trg_n),
        .deep_idle_mode_i    (deep),
        .stop_mode_i         (stopm),
        .light_idle_mode_i   (light),
        .cmp_i               (cmp),
        .analog_channel_o    (ach),
        .dac_trial_o         (trial),
        .ref_ladder_switch_o (ladder),
        .conv_done_irq_o     (irq)
    );

    adcsc_afe_model adcsc_afe_model_i (
        .clk_i               (clk),
        .analog_channel_i    (ach),
        .dac_trial_i         (trial),
        .ref_ladder_switch_i (ladder),
        .cmp_o               (cmp)
    );

    always #2 clk = ~clk;

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard: whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (irq === 1'b1) begin
            irqs++;
        end
        if (cycles == 40000) begin
            mismatches++;
            $display("[FAIL] %0t run did not finish", $time);
            tally_and_finish();
        end
    end

    function automatic logic [9:0] code_of(int ch);
        return 10'h041 + 10'(ch) * 10'h0B7;
    endfunction : code_of

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : wait_cyc

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd_reg

    task automatic expect_reg(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        `CHK(v, e)
    endtask : expect_reg

    // Counts sampling edges until the done pulse, bounded
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (irq !== 1'b1 && c < 3000);
    endtask : wait_irq

    task automatic check_pair(input int p, input int ch, input bit again);
        logic [9:0]  c;
        logic [15:0] a;
        c = code_of(ch);
        a = ADCSC_RES_LOW_BASE + 16'(2 * p);
        expect_reg(a, {c[1:0], ADCSC_LOW_ONES, 1'b1});
        expect_reg(a + 16'h0001, c[9:2]);
        if (again) begin
            expect_reg(a, {c[1:0], ADCSC_LOW_ONES, 1'b0});
        end
    endtask : check_pair

    task automatic no_store(input int p);
        rd_reg(ADCSC_RES_LOW_BASE + 16'(2 * p), d);
        `CHK(d[0], 1'b0)
    endtask : no_store

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        expect_reg(M0, 8'h00);
        expect_reg(M1, 8'h00);
        expect_reg(M2, 8'h00);
        rd_reg(ADCSC_RES_LOW_BASE, d);
        `CHK(d[5:0], 6'h3E)
        expect_reg(16'h12AA, 8'h00);
        $display("test reset done");
        // Ladder must settle for 3 us at 4 ns a cycle before any start
        wr_reg(M1, 8'h80);
        wait_cyc(750);
        for (int ch = 0; ch <= 4; ch++) begin
            wr_reg(M1, 8'h80 | 8'(ch));
            wr_reg(M0, 8'h01);
            wait_irq(n);
            `CHK(n >= 133 && n <= 136, 1'b1)
            expect_reg(M0, 8'h80);
            check_pair(ch, ch, 1'b1);
            expect_reg(M0, 8'h00);
        end
        wr_reg(ADCSC_RES_HIGH_CH4, 8'h00);
        expect_reg(ADCSC_RES_HIGH_CH4, 8'(code_of(4) >> 2));
        no_store(4);
        $display("test fixed single done");
        for (int s = 0; s <= 4; s++) begin
            wr_reg(M1, 8'h80 | 8'(s));
            wr_reg(M0, 8'h03);
            base = irqs;
            wait_irq(n);
            `CHK(n >= 133 * (s + 1) && n <= 133 * (s + 1) + 4, 1'b1)
            wait_cyc(20);
            `CHK(irqs - base, 1)
            for (int p = 0; p <= 4; p++) begin
                if (p <= s) check_pair(p, p, 1'b0);
                else no_store(p);
            end
        end
        $display("test scan single done");
        wr_reg(M0, 8'h00);
        wr_reg(M1, 8'h82);
        wr_reg(M2, 8'h01);
        base = irqs;
        trg_n <= 1'b0;
        wait_cyc(20);
        expect_reg(M0, 8'h40);
        trg_n <= 1'b1;
        wait_cyc(4);
        trg_n <= 1'b0;
        wait_irq(n);
        wait_cyc(300);
        `CHK(irqs - base, 1)
        check_pair(2, 2, 1'b0);
        wr_reg(M2, 8'h00);
        trg_n <= 1'b1;
        wait_cyc(5);
        trg_n <= 1'b0;
        wait_cyc(200);
        `CHK(irqs - base, 1)
        trg_n <= 1'b1;
        $display("test trigger done");
        wr_reg(M1, 8'h83);
        wr_reg(M0, 8'h05);
        wait_irq(n);
        wait_irq(n);
        `CHK(n >= 131 && n <= 135, 1'b1)
        rd_reg(M0, d);
        `CHK(d[7:6], 2'b11)
        expect_reg(ADCSC_RES_LOW_BASE + 16'h0001, 8'(code_of(3) >> 2));
        no_store(3);
        wr_reg(M0, 8'h00);
        rd_reg(M0, d);
        `CHK(d[6], 1'b1)
        base = irqs;
        wait_cyc(300);
        rd_reg(M0, d);
        `CHK(d[6], 1'b0)
        `CHK(irqs - base <= 1, 1'b1)
        $display("test fixed repeat done");
        wr_reg(M1, 8'h81);
        wr_reg(M0, 8'h0D);
        wait_irq(n);
        `CHK(n >= 530 && n <= 537, 1'b1)
        wait_irq(n);
        `CHK(n >= 529 && n <= 535, 1'b1)
        for (int p = 0; p <= 3; p++) check_pair(p, 1, 1'b0);
        no_store(4);
        wr_reg(M0, 8'h00);
        wait_cyc(300);
        $display("test fourth interval done");
        wr_reg(M0, 8'h07);
        wait_irq(n);
        wait_irq(n);
        `CHK(n >= 264 && n <= 268, 1'b1)
        rd_reg(M0, d);
        `CHK(d[6], 1'b1)
        wait_cyc(50);
        base = irqs;
        light <= 1'b1;
        wait_cyc(400);
        `CHK(irqs - base, 0)
        light <= 1'b0;
        wait_irq(n);
        `CHK(n >= 265 && n <= 274, 1'b1)
        wr_reg(M0, 8'h00);
        wait_cyc(300);
        $display("test scan repeat done");
        for (int p = 0; p < 3; p++) begin
            wr_reg(M0, 8'h01);
            wait_cyc(60);
            base = irqs;
            {deep, stopm, light} <= 3'b100 >> p;
            wait_cyc(300);
            {deep, stopm, light} <= 3'b000;
            wait_cyc(300);
            `CHK(irqs - base, 0)
            rd_reg(M0, d);
            `CHK(d[6], 1'b0)
        end
        // Light idle with run enable set must not stop the converter
        wr_reg(M1, 8'hA1);
        wr_reg(M0, 8'h01);
        wait_cyc(60);
        light <= 1'b1;
        wait_irq(n);
        `CHK(n >= 72 && n <= 76, 1'b1)
        light <= 1'b0;
        expect_reg(M1, 8'hA1);
        $display("test halt done");
        tally_and_finish();
    end
endmodule : tb
